// >>> shared/card_regs_pkg.sv
package card_regs_pkg;

  // register offsets on the attribute-memory select address
  localparam logic [7:0] OFS_CONFIG_OPTION = 8'h0a;
  localparam logic [7:0] OFS_CARD_STATUS = 8'h0b;
  localparam logic [7:0] OFS_SOCKET_COPY = 8'h0d;
  localparam logic [7:0] OFS_IO_EVENT = 8'h1f;

  // configuration option register fields
  localparam int CFG_INDEX_LSB = 0;
  localparam int CFG_INDEX_W = 6;
  localparam int CFG_LEVEL_BIT = 6;
  localparam int CFG_SRESET_BIT = 7;

  // card configuration and status register fields
  localparam int STS_IRQ_BIT = 1;
  localparam int STS_PWRDN_BIT = 2;
  localparam int STS_AUDIO_BIT = 3;
  localparam int STS_IOIS8_BIT = 5;
  localparam int STS_SIGCHG_BIT = 6;
  localparam int STS_CHANGED_BIT = 7;
  localparam logic [7:0] STS_WRITE_MASK = 8'h6c;

  // socket and copy register fields
  localparam int SOCKET_LSB = 0;
  localparam int SOCKET_W = 4;
  localparam int COPY_LSB = 4;
  localparam int COPY_W = 2;

  // event indication register fields
  localparam int EVT_AUX_B_BIT = 7;
  localparam int EVT_AUX_A_BIT = 6;
  localparam int EVT_PACKET_BIT = 5;
  localparam int EVT_RING_BIT = 4;
  localparam int EVT_LSB = 4;
  localparam int ENA_LSB = 0;
  localparam int EVT_W = 4;

  // reset values and the value read at unmapped offsets
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] SOCKET_COPY_RESET = 6'h00;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // pulse-mode interrupt width in master clock periods
  localparam logic [7:0] PULSE_IRQ_CYCLES = 8'hc0;

  // pin synchroniser layout: strobes idle high, rest idle low
  localparam int SYNC_W = 24;
  localparam logic [23:0] SYNC_RESET = 24'hf00000;

endpackage

// >>> rtl/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous pins and their synchronised copy
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      sync <= RESET_VAL;
    end else begin
      stage1 <= pin;
      sync <= stage1;
    end
  end

endmodule

// >>> rtl/card_event_socket_regs.sv
module card_event_socket_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // attribute memory pins
  input wire logic ce1_n,
  input wire logic reg_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // event source pins
  input wire logic aux_input_b_pin,
  input wire logic aux_input_a_pin,
  input wire logic packet_in_pin,
  input wire logic ring_in_pin,
  // card function side
  input wire logic irq_request,
  output logic soft_reset,
  output logic [5:0] config_index,
  output logic [3:0] socket_number,
  output logic [1:0] copy_number,
  output logic power_down,
  output logic audio,
  // host status signalling
  output logic stschg_n,
  output logic irq_n
);

  logic [card_regs_pkg::SYNC_W-1:0] pins_raw;
  logic [card_regs_pkg::SYNC_W-1:0] pins_s;
  logic ce1_n_s;
  logic reg_n_s;
  logic oe_n_s;
  logic we_n_s;
  logic [7:0] addr_s;
  logic [7:0] data_s;
  logic [3:0] src_s;
  logic write_active;
  logic write_prev;
  logic wr_pulse;
  logic read_active;
  logic [7:0] config_option;
  logic [7:0] card_status;
  logic [5:0] socket_copy;
  logic [3:0] events;
  logic [3:0] enables;
  logic [3:0] event_clear;
  logic [3:0] next_events;
  logic changed;
  logic sigchg;
  logic level_mode;
  logic irq_req_prev;
  logic [7:0] pulse_cnt;
  logic [7:0] next_pulse_cnt;
  logic [7:0] read_mux;

  assign pins_raw = {ce1_n, reg_n, oe_n, we_n, addr, data_in,
                     aux_input_b_pin, aux_input_a_pin,
                     packet_in_pin, ring_in_pin};

  pin_sync #(
    .WIDTH(card_regs_pkg::SYNC_W),
    .RESET_VAL(card_regs_pkg::SYNC_RESET)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin(pins_raw),
    .sync(pins_s)
  );

  assign ce1_n_s = pins_s[23];
  assign reg_n_s = pins_s[22];
  assign oe_n_s = pins_s[21];
  assign we_n_s = pins_s[20];
  assign addr_s = pins_s[19:12];
  assign data_s = pins_s[11:4];
  assign src_s = pins_s[3:0];

  // attribute-memory strobes, one write per falling we
  assign write_active = ~ce1_n_s & ~reg_n_s & ~we_n_s;
  assign read_active = ~ce1_n_s & ~reg_n_s & ~oe_n_s & we_n_s;
  assign wr_pulse = write_active & ~write_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      write_prev <= 1'b0;
    end else begin
      write_prev <= write_active;
    end
  end

  // configuration option register
  always_ff @(posedge clk) begin
    if (rst) begin
      config_option <= card_regs_pkg::CONFIG_RESET;
    end else if (wr_pulse && addr_s == card_regs_pkg::OFS_CONFIG_OPTION) begin
      config_option <= data_s;
    end
  end

  assign level_mode = config_option[card_regs_pkg::CFG_LEVEL_BIT];
  assign soft_reset = config_option[card_regs_pkg::CFG_SRESET_BIT];
  assign config_index = config_option[card_regs_pkg::CFG_INDEX_LSB +:
                                      card_regs_pkg::CFG_INDEX_W];

  // card configuration and status, host-owned bits only
  always_ff @(posedge clk) begin
    if (rst) begin
      card_status <= card_regs_pkg::STATUS_RESET;
    end else if (wr_pulse && addr_s == card_regs_pkg::OFS_CARD_STATUS) begin
      card_status <= data_s & card_regs_pkg::STS_WRITE_MASK;
    end
  end

  assign sigchg = card_status[card_regs_pkg::STS_SIGCHG_BIT];
  assign power_down = card_status[card_regs_pkg::STS_PWRDN_BIT];
  assign audio = card_status[card_regs_pkg::STS_AUDIO_BIT];

  // socket and copy register
  always_ff @(posedge clk) begin
    if (rst) begin
      socket_copy <= card_regs_pkg::SOCKET_COPY_RESET;
    end else if (wr_pulse && addr_s == card_regs_pkg::OFS_SOCKET_COPY) begin
      socket_copy <= data_s[5:0];
    end
  end

  assign socket_number = socket_copy[card_regs_pkg::SOCKET_LSB +:
                                     card_regs_pkg::SOCKET_W];
  assign copy_number = socket_copy[card_regs_pkg::COPY_LSB +:
                                   card_regs_pkg::COPY_W];

  // event bits: sticky, write one to clear, a new event wins
  assign event_clear = (wr_pulse && addr_s == card_regs_pkg::OFS_IO_EVENT)
                     ? data_s[card_regs_pkg::EVT_LSB +: card_regs_pkg::EVT_W]
                     : 4'h0;
  assign next_events = (events & ~event_clear) | src_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      events <= card_regs_pkg::EVENT_RESET;
    end else begin
      events <= next_events;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enables <= card_regs_pkg::ENABLE_RESET;
    end else if (wr_pulse && addr_s == card_regs_pkg::OFS_IO_EVENT) begin
      enables <= data_s[card_regs_pkg::ENA_LSB +: card_regs_pkg::EVT_W];
    end
  end

  // enable bit n gates event bit n+4 onto Changed
  assign changed = |(events & enables);

  always_ff @(posedge clk) begin
    if (rst) begin
      stschg_n <= 1'b1;
    end else begin
      stschg_n <= ~(changed & sigchg);
    end
  end

  // interrupt request shaping
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req_prev <= 1'b0;
    end else begin
      irq_req_prev <= irq_request;
    end
  end

  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (level_mode) begin
      next_pulse_cnt = 8'h00;
    end else if (irq_request && !irq_req_prev && pulse_cnt == 8'h00) begin
      next_pulse_cnt = card_regs_pkg::PULSE_IRQ_CYCLES;
    end else if (pulse_cnt != 8'h00) begin
      next_pulse_cnt = pulse_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_cnt <= 8'h00;
      irq_n <= 1'b1;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      irq_n <= level_mode ? ~irq_request : (next_pulse_cnt == 8'h00);
    end
  end

  // read path
  always_comb begin
    unique case (addr_s)
      card_regs_pkg::OFS_CONFIG_OPTION: read_mux = config_option;
      card_regs_pkg::OFS_CARD_STATUS: begin
        read_mux = card_status;
        read_mux[card_regs_pkg::STS_IRQ_BIT] = ~irq_n;
        read_mux[card_regs_pkg::STS_CHANGED_BIT] = changed;
      end
      card_regs_pkg::OFS_SOCKET_COPY: read_mux = {2'b00, socket_copy};
      card_regs_pkg::OFS_IO_EVENT: read_mux = {events, enables};
      default: read_mux = card_regs_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= read_mux;
      data_oe <= read_active;
    end
  end

  // checks
  AST_SOCKET_FIELD: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && addr_s == card_regs_pkg::OFS_SOCKET_COPY
    |=> socket_number == $past(data_s[3:0]))
    else $error("socket number not taken from write");

  AST_COPY_FIELD: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && addr_s == card_regs_pkg::OFS_SOCKET_COPY
    |=> copy_number == $past(data_s[5:4]))
    else $error("copy number not taken from write");

  AST_AUX_B_SET: assert property (@(posedge clk) disable iff (rst)
    src_s[3] |=> events[3])
    else $error("aux b event not latched");

  AST_AUX_A_SET: assert property (@(posedge clk) disable iff (rst)
    src_s[2] |=> events[2])
    else $error("aux a event not latched");

  AST_AUX_B_GATE: assert property (@(posedge clk) disable iff (rst)
    events[3] && enables[3] |-> changed)
    else $error("aux b enabled event without changed");

  AST_AUX_A_GATE: assert property (@(posedge clk) disable iff (rst)
    events[2] && enables[2] |-> changed)
    else $error("aux a enabled event without changed");

  AST_PACKET_SET: assert property (@(posedge clk) disable iff (rst)
    src_s[1] |=> events[1])
    else $error("packet-in event not latched");

  AST_RING_SET: assert property (@(posedge clk) disable iff (rst)
    src_s[0] |=> events[0])
    else $error("ring-in event not latched");

  AST_PACKET_GATE: assert property (@(posedge clk) disable iff (rst)
    events[1] && !enables[1] && !(events[3] && enables[3])
    && !(events[2] && enables[2]) && !(events[0] && enables[0])
    |-> !changed)
    else $error("disabled packet-in event set changed");

  AST_RING_GATE: assert property (@(posedge clk) disable iff (rst)
    events[0] && enables[0] |-> changed)
    else $error("ring-in enabled event without changed");

  AST_STSCHG_LOW: assert property (@(posedge clk) disable iff (rst)
    changed && sigchg |=> !stschg_n)
    else $error("stschg not driven low");

  AST_EVENT_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && addr_s == card_regs_pkg::OFS_IO_EVENT && data_s[5]
    && !src_s[1] |=> !events[1])
    else $error("write one did not clear packet-in event");

  AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (rst)
    $fell(irq_n) && !level_mode && !$past(level_mode)
    ##1 !level_mode [*8]
    |-> ##183 !irq_n ##1 irq_n)
    else $error("pulse interrupt width wrong");

  AST_SIGCHG_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_pulse && addr_s == card_regs_pkg::OFS_CARD_STATUS
    |=> sigchg == $past(data_s[6]))
    else $error("sigchg not written");

  AST_LEVEL_MODE: assert property (@(posedge clk) disable iff (rst)
    level_mode && irq_request |=> !irq_n)
    else $error("level interrupt not asserted");

  AST_EVENT_STICKY: assert property (@(posedge clk) disable iff (rst)
    events[0] && !event_clear[0] |=> events[0])
    else $error("ring-in event lost without clear");

  AST_STSCHG_HIGH: assert property (@(posedge clk) disable iff (rst)
    !sigchg |=> stschg_n)
    else $error("stschg low without sigchg");

endmodule

// >>> tb/host_socket_model.sv
module host_socket_model (
  // clock
  input wire logic clk,
  // attribute memory pins
  output logic ce1_n,
  output logic reg_n,
  output logic oe_n,
  output logic we_n,
  output logic [7:0] addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {ce1_n, reg_n, oe_n, we_n} = 4'hf;
    addr = 8'h00;
    data_in = 8'h00;
  end

  // strobe held past the take edge and the output update
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    data_in = d;
    {ce1_n, reg_n, we_n} = 3'h0;
    repeat (4) @(negedge clk);
    {ce1_n, reg_n, we_n} = 3'h7;
    // released lines carry no stale value
    addr = ~a;
    data_in = ~d;
    repeat (3) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    {ce1_n, reg_n, oe_n} = 3'h0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (data_oe !== 1'b1 && n < 8);
    d = (data_oe === 1'b1) ? data_out : 8'hxx;
    @(negedge clk);
    {ce1_n, reg_n, oe_n} = 3'h7;
    addr = ~a;
    repeat (4) @(negedge clk);
  endtask
endmodule

// >>> tb/tb_card_event_socket_regs.sv
module tb_card_event_socket_regs;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] A_OP = card_regs_pkg::OFS_CONFIG_OPTION;
  localparam logic [7:0] A_ST = card_regs_pkg::OFS_CARD_STATUS;
  localparam logic [7:0] A_SK = card_regs_pkg::OFS_SOCKET_COPY;
  localparam logic [7:0] A_EV = card_regs_pkg::OFS_IO_EVENT;

  logic clk, rst, ce1_n, reg_n, oe_n, we_n, data_oe, irq_request;
  logic soft_reset, power_down, audio, stschg_n, irq_n;
  logic [7:0] addr, data_in, data_out;
  logic [5:0] config_index;
  logic [3:0] socket_number, evt_pins;
  logic [1:0] copy_number;
  int num_errors = 0;
  int cmp_count = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  card_event_socket_regs DUT (
    .clk(clk), .rst(rst), .ce1_n(ce1_n), .reg_n(reg_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .aux_input_b_pin(evt_pins[3]),
    .aux_input_a_pin(evt_pins[2]), .packet_in_pin(evt_pins[1]),
    .ring_in_pin(evt_pins[0]), .irq_request(irq_request),
    .soft_reset(soft_reset), .config_index(config_index),
    .socket_number(socket_number), .copy_number(copy_number),
    .power_down(power_down), .audio(audio), .stschg_n(stschg_n),
    .irq_n(irq_n)
  );

  host_socket_model u_host (
    .clk(clk), .ce1_n(ce1_n), .reg_n(reg_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe)
  );

  task automatic close_out();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask

  // pin high for two clocks, then idle past the synchroniser
  task automatic pulse_pin(input int n);
    @(negedge clk);
    evt_pins[n] = 1'b1;
    repeat (2) @(negedge clk);
    evt_pins[n] = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_reset();
    rd_chk(A_SK, 8'h00);
    rd_chk(A_EV, 8'h00);
    chk1("stschg_n", 1'b1, stschg_n);
    chk1("irq_n", 1'b1, irq_n);
  endtask

  task automatic t_socket();
    u_host.wr(A_SK, 8'hff);
    chk("socket_number", 8'h0f, {4'h0, socket_number});
    chk("copy_number", 8'h03, {6'h00, copy_number});
    rd_chk(A_SK, 8'h3f);
    u_host.wr(A_SK, 8'h25);
    chk("socket_number", 8'h05, {4'h0, socket_number});
    chk("copy_number", 8'h02, {6'h00, copy_number});
    u_host.wr(8'h33, 8'hff);
    rd_chk(8'h33, 8'h00);
  endtask

  task automatic t_config();
    u_host.wr(A_OP, 8'hbf);
    chk1("soft_reset", 1'b1, soft_reset);
    chk("config_index", 8'h3f, {2'b00, config_index});
    rd_chk(A_OP, 8'hbf);
    u_host.wr(A_OP, 8'h00);
    chk1("soft_reset", 1'b0, soft_reset);
    u_host.wr(A_ST, 8'hff);
    chk1("power_down", 1'b1, power_down);
    chk1("audio", 1'b1, audio);
    rd_chk(A_ST, 8'h6c);
    chk1("stschg_n", 1'b1, stschg_n);
    u_host.wr(A_ST, 8'h00);
    chk1("power_down", 1'b0, power_down);
    chk1("audio", 1'b0, audio);
  endtask

  task automatic t_events();
    logic [7:0] ev, en;
    u_host.wr(A_ST, 8'h40);
    for (int n = 0; n < 4; n++) begin
      ev = 8'h10 << n;
      en = 8'h01 << n;
      pulse_pin(n);
      rd_chk(A_EV, ev);
      rd_chk(A_ST, 8'h40);
      chk1("stschg_n", 1'b1, stschg_n);
      u_host.wr(A_EV, en);
      rd_chk(A_EV, ev | en);
      rd_chk(A_ST, 8'hc0);
      chk1("stschg_n", 1'b0, stschg_n);
      u_host.wr(A_ST, 8'h00);
      chk1("stschg_n", 1'b1, stschg_n);
      u_host.wr(A_ST, 8'h40);
      u_host.wr(A_EV, ev | en);
      rd_chk(A_EV, en);
      chk1("stschg_n", 1'b1, stschg_n);
      u_host.wr(A_EV, 8'h00);
    end
  endtask

  task automatic t_irq();
    int n;
    n = 0;
    @(negedge clk);
    irq_request = 1'b1;
    while (irq_n !== 1'b0 && n < 5) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (irq_n === 1'b0 && n < 250) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk("pulse width", 8'hc0, n[7:0]);
    @(negedge clk);
    irq_request = 1'b0;
    u_host.wr(A_OP, 8'h40);
    irq_request = 1'b1;
    repeat (200) @(negedge clk);
    chk1("irq_n level", 1'b0, irq_n);
    irq_request = 1'b0;
    repeat (3) @(negedge clk);
    chk1("irq_n level", 1'b1, irq_n);
  endtask

  task automatic t_rst_clear();
    u_host.wr(A_EV, 8'h01);
    pulse_pin(0);
    chk1("stschg_n", 1'b0, stschg_n);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk(A_EV, 8'h00);
    chk1("stschg_n", 1'b1, stschg_n);
  endtask

  initial begin
    rst = 1'b1;
    evt_pins = 4'h0;
    irq_request = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_socket();
    t_config();
    t_events();
    t_irq();
    t_rst_clear();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    close_out();
  end
endmodule
